// ==== dv/cbx_exec_core_assertions.sv ====
module cbx_exec_core_assertions
    import cbx_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic [2:0]  s_axi_awprot,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [2:0]  s_axi_arprot,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------------------------------------
    // bus sequences
    // ----------------------------------------
    sequence rd_wait_s;
        !s_axi_rvalid [*2] ##1 s_axi_rvalid;
    endsequence
    sequence w_resume_s;
        !s_axi_bvalid && !s_axi_awready ##1 s_axi_awready && s_axi_wready;
    endsequence

    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> rd_wait_s)
        else $error("read answer not three cycles after address");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before rready");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_bresp_cause: assert property ($rose(s_axi_bvalid) |->
            $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
        else $error("write response without a preceding handshake");
    a_ar_drop: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("arready kept high after address taken");
    a_w_drop: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("wready kept high after data taken");
    a_single_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while response pending");
    a_write_resume: assert property (s_axi_bvalid && s_axi_bready |=> w_resume_s)
        else $error("write readies not back one cycle after response");
    a_read_resume: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_arready ##1 s_axi_arready)
        else $error("arready not back one cycle after read answer");
endmodule

bind cbx_exec_core cbx_exec_core_assertions cbx_exec_core_assertions_i (.*);

// ==== dv/cbx_exec_core_tb.sv ====
`include "cbx_consts.svh"
module cbx_exec_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata   = 32'h0000_0000;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd, exp;
    int          errors = 0;
    int          check_count = 0;
    logic [15:0] br_w [4] = '{16'hE480, 16'hE47F, 16'hE07F, 16'hE080};
    logic [31:0] br_s [4] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0004, 32'h0000_0008};
    logic [31:0] br_pc [4] = '{32'h0000_0002, 32'h0000_0102, 32'h0000_0200, 32'h0000_0102};
    logic [7:0]  rst_off [9] = '{`CBX_OFF_PC, `CBX_OFF_WREG, `CBX_OFF_STATUS, `CBX_OFF_BANK, `CBX_OFF_WSHADOW,
                                 `CBX_OFF_SSHADOW, `CBX_OFF_BSHADOW, `CBX_OFF_STACK, `CBX_OFF_CORE};

    cbx_exec_core cbx_exec_core_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    always #2.5 aclk = ~aclk;

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // waits on the answer only; the watchdog ends a stuck slave
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask

    task automatic mem(input logic [11:0] a, input logic [7:0] d);
        wr(`CBX_OFF_DADDR, {20'h0_0000, a});
        wr(`CBX_OFF_DDATA, {24'h00_0000, d});
    endtask

    // second word first: the first word starts the core
    // first poll lands five edges after go: still busy only for two-cycle ops
    task automatic ex(input logic [15:0] w2, input logic [15:0] w1, input logic two);
        wr(`CBX_OFF_INSTR2, {16'h0000, w2});
        wr(`CBX_OFF_INSTR, {16'h0000, w1});
        rdr(`CBX_OFF_CORE);
        chk({31'h0, rd[0]}, {31'h0, two});
        while (rd[0] !== 1'b0) rdr(`CBX_OFF_CORE);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        final_report();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rst_off[i]) rchk(rst_off[i], 32'h0000_0000);
        wr(8'h40, 32'h0000_0000);
        chk({30'h0, rs}, {30'h0, `CBX_RESP_SLVERR});
        rdr(8'h40);
        chk({30'h0, rs}, {30'h0, `CBX_RESP_SLVERR});
        wr(`CBX_OFF_BANK, 32'h0000_0003);
        wr(`CBX_OFF_STATUS, 32'h0000_0008);
        mem(12'h305, 8'h75);
        exp = 32'h0000_0075;
        for (int b = 0; b < 8; b++) begin
            ex(16'h0000, {4'h7, b[2:0], 1'b1, 8'h05}, 1'b0);
            exp = exp ^ (32'h0000_0001 << b);
            rchk(`CBX_OFF_DDATA, exp);
        end
        rchk(`CBX_OFF_STATUS, 32'h0000_0008);
        mem(12'h385, 8'h00);
        mem(12'hF85, 8'h00);
        ex(16'h0000, 16'h7085, 1'b0);
        rchk(`CBX_OFF_DDATA, 32'h0000_0001);
        wr(`CBX_OFF_DADDR, 32'h0000_0385);
        rchk(`CBX_OFF_DDATA, 32'h0000_0000);
        mem(12'h010, 8'h00);
        ex(16'h0000, 16'h7210, 1'b0);
        rchk(`CBX_OFF_DDATA, 32'h0000_0002);
        ex(16'h0000, 16'h6A10, 1'b0);
        rchk(`CBX_OFF_DDATA, 32'h0000_0000);
        mem(12'h305, 8'h5A);
        ex(16'h0000, 16'h6B05, 1'b0);
        rchk(`CBX_OFF_DDATA, 32'h0000_0000);
        rchk(`CBX_OFF_STATUS, 32'h0000_000C);
        ex(16'h0000, 16'h0000, 1'b0);
        rchk(`CBX_OFF_CORE, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            wr(`CBX_OFF_PC, 32'h0000_0100);
            wr(`CBX_OFF_STATUS, br_s[i]);
            ex(16'h0000, br_w[i], br_pc[i] != 32'h0000_0102);
            rchk(`CBX_OFF_PC, br_pc[i]);
            rchk(`CBX_OFF_STATUS, br_s[i]);
        end
        wr(`CBX_OFF_WREG, 32'h0000_00A5);
        wr(`CBX_OFF_STATUS, 32'h0000_000C);
        wr(`CBX_OFF_PC, 32'h0000_0100);
        ex(16'hF123, 16'hED45, 1'b1);
        rchk(`CBX_OFF_PC, 32'h0002_468A);
        rchk(`CBX_OFF_STACK, 32'h0000_0104);
        rchk(`CBX_OFF_WSHADOW, 32'h0000_00A5);
        rchk(`CBX_OFF_SSHADOW, 32'h0000_000C);
        rchk(`CBX_OFF_BSHADOW, 32'h0000_0003);
        rchk(`CBX_OFF_STATUS, 32'h0000_000C);
        wr(`CBX_OFF_WREG, 32'h0000_0011);
        wr(`CBX_OFF_BANK, 32'h0000_0005);
        ex(16'hFFFF, 16'hECFF, 1'b1);
        rchk(`CBX_OFF_PC, 32'h001F_FFFE);
        rchk(`CBX_OFF_STACK, 32'h0002_468E);
        rchk(`CBX_OFF_WSHADOW, 32'h0000_00A5);
        rchk(`CBX_OFF_BSHADOW, 32'h0000_0003);
        final_report();
    end
endmodule

// ==== rtl/cbx_consts.svh ====
`ifndef CBX_CONSTS_SVH
`define CBX_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CBX_OFF_INSTR       8'h00
`define CBX_OFF_INSTR2      8'h04
`define CBX_OFF_PC          8'h08
`define CBX_OFF_WREG        8'h0C
`define CBX_OFF_STATUS      8'h10
`define CBX_OFF_BANK        8'h14
`define CBX_OFF_WSHADOW     8'h18
`define CBX_OFF_SSHADOW     8'h1C
`define CBX_OFF_BSHADOW     8'h20
`define CBX_OFF_STACK       8'h24
`define CBX_OFF_CORE        8'h28
`define CBX_OFF_DADDR       8'h2C
`define CBX_OFF_DDATA       8'h30

// ----------------------------------------
// encodings
// ----------------------------------------
`define CBX_ENC_BITINV      4'h7
`define CBX_ENC_BRANCH_OV   8'hE4
`define CBX_ENC_BRANCH_Z    8'hE0
`define CBX_ENC_CALL        7'h76
`define CBX_ENC_CALL2       4'hF
`define CBX_ENC_CLEAR       7'h35

// ----------------------------------------
// fields, banks, reset values
// ----------------------------------------
`define CBX_STAT_Z          2
`define CBX_STAT_OV         3
`define CBX_ACCESS_SPLIT    8'h80
`define CBX_ACCESS_LO_BANK  4'h0
`define CBX_ACCESS_HI_BANK  4'hF
`define CBX_PC_STEP         21'h00_0002
`define CBX_RST_BYTE        8'h00
`define CBX_RST_PC          21'h00_0000
`define CBX_RST_WORD        16'h0000
`define CBX_RESP_OKAY       2'h0
`define CBX_RESP_SLVERR     2'h2

`endif

// ==== rtl/cbx_data_ram.sv ====
module cbx_data_ram
    import cbx_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic               aclk,
    input  wire cbx_mem_req_t       req,
    output logic [7:0]              rdata
);
    logic [7:0] mem [0:(1 << ADDR_W) - 1];

    // read-before-write: data shows the old byte one edge later
    always_ff @(posedge aclk) begin
        if (req.we) begin
            mem[req.addr[ADDR_W-1:0]] <= req.wdata;
        end
        rdata <= mem[req.addr[ADDR_W-1:0]];
    end
endmodule

// ==== rtl/cbx_decode.sv ====
`include "cbx_consts.svh"
module cbx_decode
    import cbx_pkg::*;
(
    input  wire logic [15:0]        word,
    output cbx_dec_t                dec
);
    always_comb begin
        dec.bit_idx = word[11:9];
        dec.access  = word[8];
        dec.file    = word[7:0];
        dec.lit     = word[7:0];
        dec.shadow  = word[8];
        if (word[15:12] == `CBX_ENC_BITINV) begin
            dec.op = OP_BITINV;
        end else if (word[15:8] == `CBX_ENC_BRANCH_OV) begin
            dec.op = OP_BRANCH_OV;
        end else if (word[15:8] == `CBX_ENC_BRANCH_Z) begin
            dec.op = OP_BRANCH_Z;
        end else if (word[15:9] == `CBX_ENC_CALL) begin
            dec.op = OP_CALL;
        end else if (word[15:9] == `CBX_ENC_CLEAR) begin
            dec.op = OP_CLEAR;
        end else begin
            dec.op = OP_NONE;
        end
    end
endmodule

// ==== rtl/cbx_exec_core.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "cbx_consts.svh"
// How it works
// - bit invert flips only the chosen bit of the byte, keeps the rest and leaves every flag alone.
// - bit invert is one word in one cycle: decode, read byte, process, write byte back.
// - with the access bit 0 a file operation goes to the access bank and ignores the bank select.
// - with the access bit 1 the bank comes from the bank select register.
// - branch if overflow jumps only when the overflow flag is 1, else falls through.
// - branch if zero jumps only when the zero flag is 1, else falls through.
// - a taken branch adds twice the signed offset to the already advanced counter.
// - a branch costs one cycle when not taken and two when taken, the second a full idle cycle.
// - branches and the call leave all flags unchanged.
// - a call pushes its own address plus four onto the return stack top.
// - with the shadow bit 1 a call copies accumulator, flags and bank select into shadows.
// - a call loads its 20-bit target into counter bits 20 to 1, bit 0 stays zero.
// - a call is two words and two cycles, the second cycle idle.
// - clear writes zero to the byte and sets the zero flag only, in one cycle.
module cbx_exec_core
    import cbx_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    cbx_state_t     state;
    logic           idle_cycle;
    logic           bad_op;
    logic [15:0]    instr;
    logic [15:0]    instr2;
    cbx_dec_t       dec;
    cbx_dec_t       cur;
    logic [20:0]    pc;
    logic [7:0]     accumulator;
    logic [7:0]     status;
    logic [3:0]     bank_select_reg;
    logic [7:0]     accumulator_shadow;
    logic [7:0]     flags_shadow;
    logic [3:0]     bank_select_shadow;
    logic [20:0]    return_stack_top;
    logic [7:0]     lit_lo;
    logic [7:0]     result;
    logic           jump;
    logic [11:0]    daddr;
    logic [11:0]    eff_addr;
    cbx_mem_req_t   mem_req;
    logic [7:0]     mem_rdata;

    logic           aw_got;
    logic           w_got;
    logic [7:0]     aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           wr_fire;
    logic           go;
    logic [7:0]     ar_addr;
    logic [1:0]     rd_stage;

    logic           busy;
    assign busy = (state != ST_IDLE);

    cbx_decode u_decode (
        .word (instr),
        .dec  (dec)
    );

    cbx_data_ram #(
        .ADDR_W (12)
    ) u_ram (
        .aclk  (aclk),
        .req   (mem_req),
        .rdata (mem_rdata)
    );

    // ----------------------------------------
    // bus write side
    // ----------------------------------------
    assign wr_fire = aw_got && w_got && !s_axi_bvalid;
    assign go      = wr_fire && !busy && (aw_addr == `CBX_OFF_INSTR) && w_strb[0] && w_strb[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b0;
            aw_addr       <= `CBX_RST_BYTE;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got        <= 1'b0;
        end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b0;
            w_data       <= {`CBX_RST_WORD, `CBX_RST_WORD};
            w_strb       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got        <= 1'b0;
        end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // writes to core state while busy are dropped but still answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CBX_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                `CBX_OFF_INSTR, `CBX_OFF_INSTR2, `CBX_OFF_PC, `CBX_OFF_WREG, `CBX_OFF_STATUS,
                `CBX_OFF_BANK, `CBX_OFF_WSHADOW, `CBX_OFF_SSHADOW, `CBX_OFF_BSHADOW,
                `CBX_OFF_STACK, `CBX_OFF_CORE, `CBX_OFF_DADDR, `CBX_OFF_DDATA: begin
                    s_axi_bresp <= `CBX_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `CBX_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr  <= `CBX_RST_WORD;
            instr2 <= `CBX_RST_WORD;
            daddr  <= 12'h000;
        end else if (wr_fire && !busy) begin
            if (aw_addr == `CBX_OFF_INSTR && w_strb[0] && w_strb[1]) begin
                instr <= w_data[15:0];
            end
            if (aw_addr == `CBX_OFF_INSTR2 && w_strb[0] && w_strb[1]) begin
                instr2 <= w_data[15:0];
            end
            if (aw_addr == `CBX_OFF_DADDR && w_strb[0] && w_strb[1]) begin
                daddr <= w_data[11:0];
            end
        end
    end

    // ----------------------------------------
    // quarter-phase sequencer
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_IDLE;
            idle_cycle <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        state <= ST_Q1;
                    end
                end
                ST_Q1: state <= ST_Q2;
                ST_Q2: state <= ST_Q3;
                ST_Q3: state <= ST_Q4;
                ST_Q4: begin
                    if (!idle_cycle && (jump || cur.op == OP_CALL)) begin
                        idle_cycle <= 1'b1;
                        state      <= ST_Q1;
                    end else begin
                        idle_cycle <= 1'b0;
                        state      <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // execution datapath
    // ----------------------------------------
    // branch condition: overflow flag for branch if overflow, zero flag for branch if zero
    assign jump = (cur.op == OP_BRANCH_OV && status[`CBX_STAT_OV])
               || (cur.op == OP_BRANCH_Z && status[`CBX_STAT_Z]);

    always_comb begin
        if (cur.access) begin
            eff_addr = {bank_select_reg, cur.file};
        end else if (cur.file < `CBX_ACCESS_SPLIT) begin
            eff_addr = {`CBX_ACCESS_LO_BANK, cur.file};
        end else begin
            eff_addr = {`CBX_ACCESS_HI_BANK, cur.file};
        end
    end

    // read in q2, write in q4
    always_comb begin
        mem_req.we    = 1'b0;
        mem_req.addr  = daddr;
        mem_req.wdata = w_data[7:0];
        if (busy && !idle_cycle) begin
            mem_req.addr = eff_addr;
            mem_req.we   = (state == ST_Q4) && (cur.op == OP_BITINV || cur.op == OP_CLEAR);
            mem_req.wdata = result;
        end else if (!busy && wr_fire && aw_addr == `CBX_OFF_DDATA && w_strb[0]) begin
            mem_req.we = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur    <= '0;
            lit_lo <= `CBX_RST_BYTE;
            result <= `CBX_RST_BYTE;
            bad_op <= 1'b0;
        end else if (state == ST_Q1 && !idle_cycle) begin
            cur    <= dec;
            bad_op <= (dec.op == OP_NONE);
        end else if (state == ST_Q2 && !idle_cycle) begin
            lit_lo <= cur.lit;
        end else if (state == ST_Q3 && !idle_cycle) begin
            if (cur.op == OP_BITINV) begin
                result <= mem_rdata ^ (8'h01 << cur.bit_idx);
            end else begin
                result <= `CBX_RST_BYTE;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc <= `CBX_RST_PC;
        end else if (state == ST_Q1 && !idle_cycle) begin
            pc <= pc + `CBX_PC_STEP;
        end else if (state == ST_Q4 && !idle_cycle) begin
            if (jump) begin
                pc <= pc + {{12{cur.lit[7]}}, cur.lit, 1'b0};
            end else if (cur.op == OP_CALL) begin
                pc <= {instr2[11:0], lit_lo, 1'b0};
            end
        end else if (!busy && wr_fire && aw_addr == `CBX_OFF_PC) begin
            pc <= {w_data[20:1], 1'b0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            return_stack_top   <= `CBX_RST_PC;
            accumulator_shadow <= `CBX_RST_BYTE;
            flags_shadow       <= `CBX_RST_BYTE;
            bank_select_shadow <= 4'h0;
        end else if (state == ST_Q3 && !idle_cycle && cur.op == OP_CALL) begin
            return_stack_top <= pc + `CBX_PC_STEP;
            if (cur.shadow) begin
                accumulator_shadow <= accumulator;
                flags_shadow       <= status;
                bank_select_shadow <= bank_select_reg;
            end
        end else if (!busy && wr_fire) begin
            case (aw_addr)
                `CBX_OFF_STACK:   return_stack_top   <= {w_data[20:1], 1'b0};
                `CBX_OFF_WSHADOW: accumulator_shadow <= w_data[7:0];
                `CBX_OFF_SSHADOW: flags_shadow       <= w_data[7:0];
                `CBX_OFF_BSHADOW: bank_select_shadow <= w_data[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status          <= `CBX_RST_BYTE;
            accumulator     <= `CBX_RST_BYTE;
            bank_select_reg <= 4'h0;
        end else if (state == ST_Q4 && !idle_cycle && cur.op == OP_CLEAR) begin
            status[`CBX_STAT_Z] <= 1'b1;
        end else if (!busy && wr_fire) begin
            case (aw_addr)
                `CBX_OFF_STATUS: status          <= w_data[7:0];
                `CBX_OFF_WREG:   accumulator     <= w_data[7:0];
                `CBX_OFF_BANK:   bank_select_reg <= w_data[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // bus read side
    // ----------------------------------------
    // two stages so the ram's registered data is ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            ar_addr       <= `CBX_RST_BYTE;
            rd_stage      <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            ar_addr       <= s_axi_araddr;
            rd_stage      <= 2'h1;
        end else if (rd_stage == 2'h1) begin
            rd_stage      <= 2'h2;
        end else if (rd_stage == 2'h2) begin
            rd_stage      <= 2'h0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= {`CBX_RST_WORD, `CBX_RST_WORD};
            s_axi_rresp  <= `CBX_RESP_OKAY;
        end else if (rd_stage == 2'h2) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CBX_RESP_OKAY;
            s_axi_rdata  <= {`CBX_RST_WORD, `CBX_RST_WORD};
            case (ar_addr)
                `CBX_OFF_INSTR:   s_axi_rdata[15:0] <= instr;
                `CBX_OFF_INSTR2:  s_axi_rdata[15:0] <= instr2;
                `CBX_OFF_PC:      s_axi_rdata[20:0] <= pc;
                `CBX_OFF_WREG:    s_axi_rdata[7:0]  <= accumulator;
                `CBX_OFF_STATUS:  s_axi_rdata[7:0]  <= status;
                `CBX_OFF_BANK:    s_axi_rdata[3:0]  <= bank_select_reg;
                `CBX_OFF_WSHADOW: s_axi_rdata[7:0]  <= accumulator_shadow;
                `CBX_OFF_SSHADOW: s_axi_rdata[7:0]  <= flags_shadow;
                `CBX_OFF_BSHADOW: s_axi_rdata[3:0]  <= bank_select_shadow;
                `CBX_OFF_STACK:   s_axi_rdata[20:0] <= return_stack_top;
                `CBX_OFF_CORE:    s_axi_rdata[1:0]  <= {bad_op, busy};
                `CBX_OFF_DADDR:   s_axi_rdata[11:0] <= daddr;
                `CBX_OFF_DDATA: begin
                    // ram port belongs to the core while it runs
                    if (busy) begin
                        s_axi_rresp <= `CBX_RESP_SLVERR;
                    end else begin
                        s_axi_rdata[7:0] <= mem_rdata;
                    end
                end
                default: s_axi_rresp <= `CBX_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== rtl/cbx_pkg.sv ====
package cbx_pkg;

    typedef enum logic [5:0] {
        OP_NONE       = 6'b00_0001,
        OP_BITINV     = 6'b00_0010,
        OP_BRANCH_OV  = 6'b00_0100,
        OP_BRANCH_Z   = 6'b00_1000,
        OP_CALL       = 6'b01_0000,
        OP_CLEAR      = 6'b10_0000
    } cbx_op_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_Q1   = 5'b0_0010,
        ST_Q2   = 5'b0_0100,
        ST_Q3   = 5'b0_1000,
        ST_Q4   = 5'b1_0000
    } cbx_state_t;

    typedef struct packed {
        cbx_op_t    op;
        logic [2:0] bit_idx;
        logic       access;
        logic [7:0] file;
        logic [7:0] lit;
        logic       shadow;
    } cbx_dec_t;

    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } cbx_mem_req_t;

endpackage
